// >>> logic/bbc_pkg.sv
// Purpose: constants and types for the battery backed calendar clock
// Assumes: 20 MHz clock, bcd coded fields
// Notes:   register indices are the word positions of the special area
package bbc_pkg;
  // ------------------------------------------------------------
  // register indices and codes
  // ------------------------------------------------------------
  localparam logic [2:0]  IDX_HOUR_MINUTE_VIEW  = 3'h0;
  localparam logic [2:0]  IDX_MINUTE_SECOND_REG = 3'h1;
  localparam logic [2:0]  IDX_DAY_HOUR_REG      = 3'h2;
  localparam logic [2:0]  IDX_YEAR_MONTH_REG    = 3'h3;
  localparam logic [2:0]  IDX_WEEKDAY_REG       = 3'h4;
  localparam logic [2:0]  IDX_CLOCK_SET_TRIGGER = 3'h5;
  localparam logic [15:0] SET_CODE              = 16'h8000;
  localparam logic [15:0] IDLE_CODE             = 16'h0000;
  localparam logic [15:0] READ_ZERO             = 16'h0000;
  // ------------------------------------------------------------
  // bcd limits
  // ------------------------------------------------------------
  localparam logic [7:0] BCD_ZERO    = 8'h00;
  localparam logic [7:0] BCD_ONE     = 8'h01;
  localparam logic [7:0] SEC_MAX     = 8'h59;
  localparam logic [7:0] MIN_MAX     = 8'h59;
  localparam logic [7:0] HOUR_MAX    = 8'h23;
  localparam logic [7:0] MONTH_MAX   = 8'h12;
  localparam logic [7:0] YEAR_MAX    = 8'h99;
  localparam logic [7:0] WEEKDAY_MAX = 8'h06;
  localparam logic [7:0] FEB         = 8'h02;
  localparam logic [7:0] DAYS_28     = 8'h28;
  localparam logic [7:0] DAYS_29     = 8'h29;
  localparam logic [7:0] DAYS_30     = 8'h30;
  localparam logic [7:0] DAYS_31     = 8'h31;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [7:0] weekday;
  } bbc_time_t;
  typedef struct packed {
    logic        write;
    logic [2:0]  index;
    logic [15:0] data;
  } bbc_access_t;
endpackage

// >>> logic/bbc_tick.sv
// Purpose: one pulse per second from the system clock
// Assumes: synchronous active high reset
// Notes:   count length is a parameter so simulation can shorten it
module bbc_tick #(
  parameter int unsigned CYCLES = bbc_pkg::TICK_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  wire         at_end = (count_reg == 32'(CYCLES - 1));

  assign count_next = (clear_in || at_end) ? 32'h0 : count_reg + 32'h1;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      count_reg <= 32'h0;
      tick_out  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_out  <= at_end && !clear_in;
    end
  end
endmodule

// >>> logic/bbc_clock.sv
// Purpose: battery backed clock and calendar in special registers
// Assumes: one register access per cycle, synchronous inputs
// Notes:   all fields bcd; contents invalid until first set
module bbc_clock #(
  parameter int unsigned TICK_CYCLES = bbc_pkg::TICK_CYCLES
) (
  input  wire logic                 clock_in,
  input  wire logic                 reset_in,
  input  wire logic                 battery_fitted_in,
  input  wire bbc_pkg::bbc_access_t access_in,
  output logic [15:0]               read_data_out,
  output logic                      time_valid_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                  : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                     || yr[3:0] == 4'h8));
    case (mon)
      bbc_pkg::FEB: return leap ? bbc_pkg::DAYS_29 : bbc_pkg::DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: return bbc_pkg::DAYS_30;
      default: return bbc_pkg::DAYS_31;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum {ST_UNSET, ST_RUN, ST_DEAD} bbc_state_t;
  bbc_state_t        state_reg;
  bbc_state_t        state_next;
  bbc_pkg::bbc_time_t run_reg;
  bbc_pkg::bbc_time_t run_next;
  bbc_pkg::bbc_time_t stage_reg;
  bbc_pkg::bbc_time_t stage_next;
  logic [15:0]       read_next;
  logic              tick;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  wire wr = access_in.write;
  wire [2:0] idx = access_in.index;
  wire [15:0] wd = access_in.data;
  wire set_hit = wr && idx == bbc_pkg::IDX_CLOCK_SET_TRIGGER
                 && wd == bbc_pkg::SET_CODE;
  wire load = set_hit && battery_fitted_in;
  wire running = battery_fitted_in && state_reg == ST_RUN;

  bbc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .clear_in (load || !running),
    .tick_out (tick)
  );

  // ------------------------------------------------------------
  // staging writes
  // ------------------------------------------------------------
  // stage setting writes
  always_comb
  begin
    stage_next = stage_reg;
    if (wr)
    begin
      case (idx)
        bbc_pkg::IDX_MINUTE_SECOND_REG:
        begin
          stage_next.minute = wd[15:8];
          stage_next.second = wd[7:0];
        end
        bbc_pkg::IDX_DAY_HOUR_REG:
        begin
          stage_next.day  = wd[15:8];
          stage_next.hour = wd[7:0];
        end
        bbc_pkg::IDX_YEAR_MONTH_REG:
        begin
          stage_next.year  = wd[15:8];
          stage_next.month = wd[7:0];
        end
        bbc_pkg::IDX_WEEKDAY_REG: stage_next.weekday = wd[7:0];
        default: stage_next = stage_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // running clock
  // ------------------------------------------------------------
  wire [7:0] last_day = month_days(run_reg.month, run_reg.year);
  wire c_sec  = run_reg.second == bbc_pkg::SEC_MAX;
  wire c_min  = c_sec && run_reg.minute == bbc_pkg::MIN_MAX;
  wire c_hour = c_min && run_reg.hour == bbc_pkg::HOUR_MAX;
  wire c_day  = c_hour && run_reg.day == last_day;
  wire c_mon  = c_day && run_reg.month == bbc_pkg::MONTH_MAX;

  always_comb
  begin
    run_next = run_reg;
    if (load)
      run_next = stage_reg;
    else if (running && tick)
    begin
      run_next.second = c_sec ? bbc_pkg::BCD_ZERO : bcd_inc(run_reg.second);
      if (c_sec)
        run_next.minute = c_min ? bbc_pkg::BCD_ZERO
                                : bcd_inc(run_reg.minute);
      if (c_min)
        run_next.hour = c_hour ? bbc_pkg::BCD_ZERO : bcd_inc(run_reg.hour);
      if (c_hour)
      begin
        run_next.day = c_day ? bbc_pkg::BCD_ONE : bcd_inc(run_reg.day);
        run_next.weekday = (run_reg.weekday >= bbc_pkg::WEEKDAY_MAX)
                           ? bbc_pkg::BCD_ZERO : bcd_inc(run_reg.weekday);
      end
      if (c_day)
        run_next.month = c_mon ? bbc_pkg::BCD_ONE : bcd_inc(run_reg.month);
      if (c_mon)
        run_next.year = (run_reg.year == bbc_pkg::YEAR_MAX)
                        ? bbc_pkg::BCD_ZERO : bcd_inc(run_reg.year);
    end
  end

  // ------------------------------------------------------------
  // validity state
  // ------------------------------------------------------------
  // unset until loaded
  always_comb
  begin
    case (state_reg)
      ST_UNSET: state_next = load ? ST_RUN : ST_UNSET;
      ST_RUN:   state_next = battery_fitted_in ? ST_RUN : ST_DEAD;
      ST_DEAD:  state_next = load ? ST_RUN : ST_DEAD;
      default:  state_next = ST_UNSET;
    endcase
  end

  // ------------------------------------------------------------
  // read view
  // ------------------------------------------------------------
  // five readable registers
  always_comb
  begin
    case (idx)
      bbc_pkg::IDX_HOUR_MINUTE_VIEW:
        read_next = {run_reg.hour, run_reg.minute};
      bbc_pkg::IDX_MINUTE_SECOND_REG:
        read_next = {run_reg.minute, run_reg.second};
      bbc_pkg::IDX_DAY_HOUR_REG:
        read_next = {run_reg.day, run_reg.hour};
      bbc_pkg::IDX_YEAR_MONTH_REG:
        read_next = {run_reg.year, run_reg.month};
      bbc_pkg::IDX_WEEKDAY_REG:
        read_next = {8'h00, run_reg.weekday};
      default: read_next = bbc_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      state_reg     <= ST_UNSET;
      run_reg       <= '0;
      stage_reg     <= '0;
      read_data_out <= 16'h0000;
      time_valid_out <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      run_reg       <= run_next;
      stage_reg     <= stage_next;
      read_data_out <= read_next;
      time_valid_out <= battery_fitted_in && state_next == ST_RUN;
    end
  end
endmodule

// >>> dv/bbc_clock_assertions.sv
// Purpose: port checks for bbc_clock
// Assumes: one access per cycle
// Notes:   bound after the module
module bbc_clock_assertions #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic                 clock_in,
  input wire logic                 reset_in,
  input wire logic                 battery_fitted_in,
  input wire bbc_pkg::bbc_access_t access_in,
  input wire logic [15:0]          read_data_out,
  input wire logic                 time_valid_out
);
  // ----------
  // properties
  // ----------
  wire logic [2:0] ix = access_in.index;
  wire logic       wr = access_in.write;
  wire logic       trg = wr && ix == 3'h5 && access_in.data == 16'h8000
                         && battery_fitted_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_batt; !battery_fitted_in |=> !time_valid_out; endproperty
  a_batt: assert property (p_batt) else $error("valid w/o battery");
  property p_rst;
    $past(reset_in) |-> !time_valid_out && read_data_out == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_load; trg |=> time_valid_out; endproperty
  a_load: assert property (p_load) else $error("set code ignored");
  property p_view;
    ix == 3'h0 |=> read_data_out[15:8] <= 8'h23 && read_data_out[7:0] <= 8'h59;
  endproperty
  a_view: assert property (p_view) else $error("view out of range");
  property p_ms;
    ix == 3'h1 |=> read_data_out[15:8] <= 8'h59 && read_data_out[7:0] <= 8'h59;
  endproperty
  a_ms: assert property (p_ms) else $error("min sec out of range");
  property p_wday; ix == 3'h4 |=> read_data_out <= 16'h0006; endproperty
  a_wday: assert property (p_wday) else $error("bad weekday");
  property p_stage;
    (wr && ix == 3'h4) ##1 trg ##1 (!wr && ix == 3'h4)
      |=> read_data_out == $past(access_in.data, 3);
  endproperty
  a_stage: assert property (p_stage) else $error("staged not loaded");
  property p_unmap; ix > 3'h5 |=> read_data_out == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  c_load: cover property (trg);
  c_view: cover property (time_valid_out && ix == 3'h0);
  c_batt: cover property (!battery_fitted_in && wr && ix == 3'h5);
endmodule

bind bbc_clock bbc_clock_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .battery_fitted_in(battery_fitted_in),
  .access_in(access_in),
  .read_data_out(read_data_out),
  .time_valid_out(time_valid_out)
);

// >>> dv/tb_bbc_clock.sv
// Purpose: self-checking bench for bbc_clock
// Assumes: tick shortened to TICK cycles
// Notes:   inputs change on the falling edge
module tb_bbc_clock;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICK = 40;
  logic                 clock_in;
  logic                 reset_in;
  logic                 battery_fitted_in;
  bbc_pkg::bbc_access_t access_in;
  logic [15:0]          read_data_out;
  logic                 time_valid_out;
  int                   errors = 0;
  int                   checked = 0;
  int                   cycles = 0;
  bbc_clock #(
    .TICK_CYCLES(TICK)
  ) u_dut (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .battery_fitted_in(battery_fitted_in),
    .access_in(access_in),
    .read_data_out(read_data_out),
    .time_valid_out(time_valid_out)
  );
  // -----
  // tasks
  // -----
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic report_and_stop();
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_valid(input logic e);
    checked++;
    if (time_valid_out !== e)
    begin
      errors++;
      $display("BAD valid exp %h got %h", e, time_valid_out);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    @(negedge clock_in);
    access_in = '{1'b1, i, d};
  endtask
  task automatic rd(input logic [2:0] i, input logic [15:0] e);
    @(negedge clock_in);
    access_in = '{1'b0, i, 16'h0000};
    @(negedge clock_in);
    chk("read_data", e, read_data_out);
  endtask
  task automatic roll(input logic [15:0] ym, input logic [7:0] d, w,
                      input logic [15:0] eym, input logic [7:0] ed, ew);
    wr(3'h1, 16'h5959);
    wr(3'h2, {d, 8'h23});
    wr(3'h3, ym);
    wr(3'h4, {8'h00, w});
    wr(3'h5, 16'h8000);
    rd(3'h4, {8'h00, w});
    rd(3'h0, 16'h2359);
    chk_valid(1'b1);
    repeat (TICK) @(negedge clock_in);
    rd(3'h1, 16'h0000);
    rd(3'h2, {ed, 8'h00});
    rd(3'h3, eym);
    rd(3'h4, {8'h00, ew});
    rd(3'h0, 16'h0000);
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    reset_in = 1'b1;
    battery_fitted_in = 1'b1;
    access_in = '{1'b0, 3'h0, 16'h0000};
    repeat (10) @(negedge clock_in);
    reset_in = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(3'(i), 16'h0000);
    chk_valid(1'b0);
    roll(16'h9912, 8'h31, 8'h06, 16'h0001, 8'h01, 8'h00);
    roll(16'h0402, 8'h28, 8'h02, 16'h0402, 8'h29, 8'h03);
    roll(16'h0302, 8'h28, 8'h03, 16'h0303, 8'h01, 8'h04);
    roll(16'h0304, 8'h30, 8'h04, 16'h0305, 8'h01, 8'h05);
    roll(16'h0301, 8'h30, 8'h05, 16'h0301, 8'h31, 8'h06);
    reset_in = 1'b1;
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    rd(3'h2, 16'h0000);
    chk_valid(1'b0);
    wr(3'h0, 16'h1111);
    wr(3'h1, 16'h4444);
    wr(3'h5, 16'h1234);
    rd(3'h0, 16'h0000);
    rd(3'h1, 16'h0000);
    battery_fitted_in = 1'b0;
    wr(3'h5, 16'h8000);
    rd(3'h1, 16'h0000);
    chk_valid(1'b0);
    repeat (2 * TICK) @(negedge clock_in);
    rd(3'h1, 16'h0000);
    battery_fitted_in = 1'b1;
    rd(3'h6, 16'h0000);
    chk_valid(1'b0);
    wr(3'h5, 16'h8000);
    rd(3'h1, 16'h4444);
    chk_valid(1'b1);
    report_and_stop();
  end
endmodule
